// >>> logic/alarm_edge_filter.sv
`timescale 1ns/10ps
`default_nettype none

// Accepts a new input level only after it has held steady for the hold time.
module alarm_edge_filter
  import motor_alarm_pkg::*;
#(
  parameter int HOLD_CYC = 100000
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic level_o,
  output logic fall_o
);

  logic [16:0] hold_count;

  // ----------------------------------------------------------------------------
  // Hold counter
  // ----------------------------------------------------------------------------

  // Glitches shorter than the hold time restart the count and never pass.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_count <= 17'h00000;
    end else if (level_i == level_o) begin
      hold_count <= 17'h00000;
    end else if (hold_count < 17'(HOLD_CYC - 1)) begin
      hold_count <= hold_count + 17'h00001;
    end else begin
      hold_count <= 17'h00000;
    end
  end

  // Accepted level and its falling edge pulse.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= 1'b0;
      fall_o <= 1'b0;
    end else if (level_i != level_o && hold_count >= 17'(HOLD_CYC - 1)) begin
      level_o <= level_i;
      fall_o <= level_o & ~level_i;
    end else begin
      fall_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> logic/blink_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

`include "motor_alarm_defs.svh"

// Blinks the red indicator code times, pauses, and repeats; the steady code lights it steadily instead.
module blink_sequencer
  import motor_alarm_pkg::*;
#(
  parameter int PHASE_CYC = 2000000,
  parameter int GAP_CYC = 10000000
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [`ALARM_CODE_W-1:0] code_i,
  output logic red_o
);

  blink_state_t state;
  logic [23:0] timer;
  logic [`ALARM_CODE_W-1:0] blinks_left;

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------

  // Only a change to no alarm or the steady code restarts from idle; other code changes wait for the next idle.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= BLINK_IDLE;
      timer <= 24'h000000;
      blinks_left <= `ALARM_NONE;
      red_o <= 1'b0;
    end else if (code_i == `ALARM_NONE) begin
      state <= BLINK_IDLE;
      red_o <= 1'b0;
    end else if (code_i == `ALARM_STEADY) begin
      state <= BLINK_IDLE;
      red_o <= 1'b1;
    end else begin
      case (state)
        BLINK_IDLE: begin
          state <= BLINK_ON;
          timer <= 24'(PHASE_CYC - 1);
          blinks_left <= code_i;
          red_o <= 1'b1;
        end
        BLINK_ON: begin
          if (timer == 24'h000000) begin
            state <= BLINK_OFF;
            timer <= 24'(PHASE_CYC - 1);
            blinks_left <= blinks_left - 4'h1;
            red_o <= 1'b0;
          end else begin
            timer <= timer - 24'h000001;
          end
        end
        BLINK_OFF: begin
          if (timer != 24'h000000) begin
            timer <= timer - 24'h000001;
          end else if (blinks_left == `ALARM_NONE) begin
            state <= BLINK_GAP;
            timer <= 24'(GAP_CYC - 1);
          end else begin
            state <= BLINK_ON;
            timer <= 24'(PHASE_CYC - 1);
            red_o <= 1'b1;
          end
        end
        default: begin
          if (timer == 24'h000000) begin
            state <= BLINK_IDLE;
          end else begin
            timer <= timer - 24'h000001;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> logic/motor_alarm_defs.svh
`ifndef MOTOR_ALARM_DEFS_SVH
`define MOTOR_ALARM_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing constants
// ----------------------------------------------------------------------------

// Clock period in nanoseconds.
`define CLK_PERIOD_NS 100
// Blink on and off phase length in milliseconds.
`define BLINK_PHASE_MS 200
// Pause between blink groups in milliseconds.
`define BLINK_GAP_MS 1000
// Least hold time of an input level in milliseconds.
`define INPUT_HOLD_MS 10
// Cycle counts derived from the times and the clock rate.
`define BLINK_PHASE_CYC ((`BLINK_PHASE_MS * 1000000) / `CLK_PERIOD_NS)
`define BLINK_GAP_CYC ((`BLINK_GAP_MS * 1000000) / `CLK_PERIOD_NS)
`define INPUT_HOLD_CYC ((`INPUT_HOLD_MS * 1000000) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Alarm codes and field positions
// ----------------------------------------------------------------------------

// Width of the alarm cause code, which is also its blink count.
`define ALARM_CODE_W 4
// Code value meaning no alarm.
`define ALARM_NONE 4'h0
// First code of the range that the clear input cannot clear.
`define ALARM_FIRST_FATAL 4'h7
// Last code of the range that the clear input cannot clear.
`define ALARM_LAST_FATAL 4'h8
// Code that lights the indicator steadily rather than blinking.
`define ALARM_STEADY 4'hA

`endif

// >>> logic/motor_alarm_pkg.sv
package motor_alarm_pkg;

  // Stop behaviour commanded to the drive stage.
  typedef enum logic [1:0] {
    STOP_NONE,
    STOP_DECEL,
    STOP_FAST,
    STOP_COAST
  } stop_mode_t;

  // Blink sequencer states.
  typedef enum logic [1:0] {
    BLINK_IDLE,
    BLINK_ON,
    BLINK_OFF,
    BLINK_GAP
  } blink_state_t;

endpackage

// >>> logic/motor_alarm_run_control.sv
`timescale 1ns/10ps
`default_nettype none

`include "motor_alarm_defs.svh"

module motor_alarm_run_control
  import motor_alarm_pkg::*;
#(
  parameter int HOLD_CYC = `INPUT_HOLD_CYC,
  parameter int PHASE_CYC = `BLINK_PHASE_CYC,
  parameter int GAP_CYC = `BLINK_GAP_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic run_request_i,
  input wire logic hold_release_input_i,
  input wire logic direction_select_input_i,
  input wire logic speed_source_select_i,
  input wire logic alarm_clear_input_i,
  input wire logic [`ALARM_CODE_W-1:0] alarm_cause_i,
  input wire logic motor_turning_i,
  output logic alarm_inactive_output_o,
  output logic power_alarm_indicator_red_o,
  output logic power_alarm_indicator_green_o,
  output logic [`ALARM_CODE_W-1:0] alarm_code_o,
  output logic drive_enable_o,
  output logic direction_cw_o,
  output logic use_internal_speed_pot_o,
  output var stop_mode_t stop_mode_o
);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------

  // Codes in the fatal range survive the clear input.
  function automatic logic is_fatal(input logic [`ALARM_CODE_W-1:0] code);
    is_fatal = (code >= `ALARM_FIRST_FATAL && code <= `ALARM_LAST_FATAL) ||
               (code == `ALARM_STEADY);
  endfunction

  // A detector reports a cause with any code other than the idle one.
  function automatic logic cause_present(input logic [`ALARM_CODE_W-1:0] code);
    cause_present = (code != `ALARM_NONE);
  endfunction

  logic run_level;
  logic hold_level;
  logic dir_level;
  logic sel_level;
  logic clear_level;
  logic clear_fall;
  logic alarm_latched;
  logic [`ALARM_CODE_W-1:0] alarm_code;
  logic run_prev;
  logic hold_prev;
  logic next_drive;
  logic clear_ok;
  logic cause_now;
  logic clear_allowed;
  logic clear_resettable;
  logic alarm_set;
  logic alarm_release;
  logic alarm_reload;
  stop_mode_t next_stop_mode;

  // ----------------------------------------------------------------------------
  // Input qualification
  // ----------------------------------------------------------------------------

  // Each controller input needs a steady level for the hold time, so short noise is rejected.
  alarm_edge_filter #(.HOLD_CYC(HOLD_CYC)) u_run_filt (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .level_i(run_request_i),
    .level_o(run_level),
    .fall_o()
  );

  // The hold release filter, so one contact bounce cannot trigger a fast stop.
  alarm_edge_filter #(.HOLD_CYC(HOLD_CYC)) u_hold_filt (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .level_i(hold_release_input_i),
    .level_o(hold_level),
    .fall_o()
  );

  // The direction select filter.
  alarm_edge_filter #(.HOLD_CYC(HOLD_CYC)) u_dir_filt (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .level_i(direction_select_input_i),
    .level_o(dir_level),
    .fall_o()
  );

  // The speed source select filter.
  alarm_edge_filter #(.HOLD_CYC(HOLD_CYC)) u_sel_filt (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .level_i(speed_source_select_i),
    .level_o(sel_level),
    .fall_o()
  );

  // The clear filter also gives the falling edge pulse that clears an alarm.
  alarm_edge_filter #(.HOLD_CYC(HOLD_CYC)) u_clr_filt (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .level_i(alarm_clear_input_i),
    .level_o(clear_level),
    .fall_o(clear_fall)
  );

  // ----------------------------------------------------------------------------
  // Alarm latch
  // ----------------------------------------------------------------------------

  // A detector cause is acted on in the cycle it is reported.
  assign cause_now = cause_present(alarm_cause_i);

  // Clearing is refused while the run request is accepted high.
  assign clear_allowed = ~run_level;

  // Non-resettable codes wait for a power-up instead.
  assign clear_resettable = ~is_fatal(alarm_code);

  // Only the falling edge clears, never the rising one.
  assign clear_ok = clear_fall & clear_allowed & clear_resettable;

  // A first cause latches; a later one only shows after a clear.
  assign alarm_set = ~alarm_latched & cause_now;

  // A clear that meets a cause still present only reloads the code.
  assign alarm_release = alarm_latched & clear_ok & ~cause_now;
  assign alarm_reload = alarm_latched & clear_ok & cause_now;

  // The latched flag; a set in the clear cycle wins, so no alarm is lost to a clear.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_latched <= 1'b0;
    end else if (alarm_set) begin
      alarm_latched <= 1'b1;
    end else if (alarm_release) begin
      alarm_latched <= 1'b0;
    end
  end

  // The cause code, kept after the cause itself has gone away.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_code <= `ALARM_NONE;
    end else if (alarm_set || alarm_reload) begin
      alarm_code <= alarm_cause_i;
    end else if (alarm_release) begin
      alarm_code <= `ALARM_NONE;
    end
  end

  // ----------------------------------------------------------------------------
  // Run gating and stop mode
  // ----------------------------------------------------------------------------

  // Drive only with both inputs active and no alarm, whatever the inputs do meanwhile.
  always_comb begin
    next_drive = run_level & hold_level & ~alarm_latched;
  end

  // Previous accepted run level, used to tell which input caused a stop.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_prev <= 1'b0;
    end else begin
      run_prev <= run_level;
    end
  end

  // Previous accepted hold release level, for the same purpose.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_prev <= 1'b0;
    end else begin
      hold_prev <= hold_level;
    end
  end

  // ----------------------------------------------------------------------------
  // Stop mode
  // ----------------------------------------------------------------------------

  // Hold release dropping wins over run request dropping, and later upgrades a ramp.
  always_comb begin
    next_stop_mode = stop_mode_o;
    if (alarm_latched || cause_now) begin
      next_stop_mode = STOP_COAST;
    end else if (next_drive) begin
      next_stop_mode = STOP_NONE;
    end else if (!hold_level && (hold_prev || stop_mode_o == STOP_DECEL)) begin
      next_stop_mode = STOP_FAST;
    end else if (!run_level && run_prev && hold_level && motor_turning_i) begin
      next_stop_mode = STOP_DECEL;
    end else if (stop_mode_o == STOP_COAST) begin
      next_stop_mode = STOP_NONE;
    end
  end

  // Fast and decel stops hold until the motor runs again; coast returns to none once the alarm clears.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_mode_o <= STOP_NONE;
    end else begin
      stop_mode_o <= next_stop_mode;
    end
  end

  // ----------------------------------------------------------------------------
  // Drive outputs
  // ----------------------------------------------------------------------------

  // Drive drops the cycle after a cause appears, so the motor coasts without braking.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_enable_o <= 1'b0;
    end else begin
      drive_enable_o <= next_drive & ~cause_now;
    end
  end

  // Direction follows the accepted select level.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      direction_cw_o <= 1'b0;
    end else begin
      direction_cw_o <= dir_level;
    end
  end

  // Speed source follows the accepted select level.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      use_internal_speed_pot_o <= 1'b0;
    end else begin
      use_internal_speed_pot_o <= sel_level;
    end
  end

  // ----------------------------------------------------------------------------
  // Alarm output and indicator
  // ----------------------------------------------------------------------------

  // The alarm output is high while healthy, so a broken wire reads as an alarm.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_inactive_output_o <= 1'b0;
    end else begin
      alarm_inactive_output_o <= ~alarm_latched & ~cause_now;
    end
  end

  // Green marks a healthy drive and stays dark while any alarm is latched.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_alarm_indicator_green_o <= 1'b0;
    end else begin
      power_alarm_indicator_green_o <= ~alarm_latched;
    end
  end

  // The code output trails the latch by one cycle, in step with the first red flash.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_code_o <= `ALARM_NONE;
    end else begin
      alarm_code_o <= alarm_code;
    end
  end

  blink_sequencer #(.PHASE_CYC(PHASE_CYC), .GAP_CYC(GAP_CYC)) u_blink (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .code_i(alarm_code),
    .red_o(power_alarm_indicator_red_o)
  );

endmodule

`default_nettype wire

// >>> verif/ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// External controller: bit 0 run, 1 hold release, 2 direction, 3 speed, 4 clear
// ----------------------------------------------------------------------------
module ctrl_model #(
  parameter int MIN_HOLD = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] want_i,
  input wire logic rude_i,
  output logic [4:0] lvl_o
);
  int age;
  logic keep_clr;
  // Unless told to misbehave, the clear line stays put while run is asked for or on.
  assign keep_clr = !rude_i && (want_i[0] || lvl_o[0]);
  // One shared age keeps every line still for the hold time, which is stricter than needed.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_o <= 5'h00;
      age <= MIN_HOLD;
    end else if (age < MIN_HOLD) begin
      age <= age + 1;
    end else if (want_i != lvl_o) begin
      lvl_o <= keep_clr ? {lvl_o[4], want_i[3:0]} : want_i;
      age <= 0;
    end
  end
endmodule
`default_nettype wire

// >>> verif/motor_alarm_run_control_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "motor_alarm_defs.svh"
// ----------------------------------------------------------------------------
// Alarm and run gating properties
// ----------------------------------------------------------------------------
module motor_alarm_run_control_props
  import motor_alarm_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic run_request_i,
  input wire logic hold_release_input_i,
  input wire logic direction_select_input_i,
  input wire logic speed_source_select_i,
  input wire logic alarm_clear_input_i,
  input wire logic [`ALARM_CODE_W-1:0] alarm_cause_i,
  input wire logic alarm_inactive_output_o,
  input wire logic power_alarm_indicator_red_o,
  input wire logic [`ALARM_CODE_W-1:0] alarm_code_o,
  input wire logic drive_enable_o,
  input wire logic direction_cw_o,
  input wire logic use_internal_speed_pot_o,
  input var stop_mode_t stop_mode_o
);
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // A rise right after reset is the power-on release, not a clear, so it is excluded.
  sequence s_cleared;
    $past(rst_n_i) && $past(rst_n_i, 2) && $rose(alarm_inactive_output_o);
  endsequence
  AST_ALARM_STOP: assert property (
    alarm_cause_i != 4'h0 |=> !alarm_inactive_output_o && !drive_enable_o)
    else $error("alarm did not stop drive");
  AST_COAST: assert property (
    alarm_cause_i != 4'h0 |=> stop_mode_o == STOP_COAST)
    else $error("alarm did not coast");
  AST_RED_ALARM: assert property (
    power_alarm_indicator_red_o |-> !alarm_inactive_output_o)
    else $error("red lit without alarm");
  AST_LATCH_HOLD: assert property (
    (alarm_code_o != 4'h0 && alarm_cause_i == 4'h0 && alarm_clear_input_i)[*6]
    |=> $stable(alarm_code_o))
    else $error("latched code changed");
  AST_FATAL_KEEP: assert property (
    alarm_code_o inside {4'h7, 4'h8, 4'hA} |=> alarm_code_o != 4'h0)
    else $error("fatal code cleared");
  AST_RUN_BLOCK: assert property (
    drive_enable_o |-> alarm_inactive_output_o)
    else $error("drive while alarm");
  AST_DRIVE_CAUSE: assert property (
    $rose(drive_enable_o) |-> $past(run_request_i, 2) && $past(hold_release_input_i, 2))
    else $error("drive without both inputs");
  AST_DIR: assert property (
    $changed(direction_cw_o) |-> direction_cw_o == $past(direction_select_input_i, 2))
    else $error("direction mismatch");
  AST_SPEED_SRC: assert property (
    $changed(use_internal_speed_pot_o)
    |-> use_internal_speed_pot_o == $past(speed_source_select_i, 2))
    else $error("speed source mismatch");
  AST_CLEAR_EDGE: assert property (
    s_cleared |-> !$past(alarm_clear_input_i, 2) && !$past(run_request_i, 2))
    else $error("clear without falling edge or with run on");
  AST_POWER_ON: assert property (
    rst_n_i && !$past(rst_n_i) && alarm_cause_i == 4'h0
    |=> alarm_inactive_output_o && alarm_code_o == 4'h0)
    else $error("alarm not clear after power on");
endmodule

bind motor_alarm_run_control motor_alarm_run_control_props u_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .run_request_i(run_request_i),
  .hold_release_input_i(hold_release_input_i),
  .direction_select_input_i(direction_select_input_i),
  .speed_source_select_i(speed_source_select_i), .alarm_clear_input_i(alarm_clear_input_i),
  .alarm_cause_i(alarm_cause_i), .alarm_inactive_output_o(alarm_inactive_output_o),
  .power_alarm_indicator_red_o(power_alarm_indicator_red_o), .alarm_code_o(alarm_code_o),
  .drive_enable_o(drive_enable_o), .direction_cw_o(direction_cw_o),
  .use_internal_speed_pot_o(use_internal_speed_pot_o), .stop_mode_o(stop_mode_o)
);
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "motor_alarm_defs.svh"
// ----------------------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------------------
module tb_top
  import motor_alarm_pkg::*;
;
  localparam int HOLD = 4;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] want = 5'h00;
  logic rude = 1'b0;
  logic [4:0] lvl;
  logic [3:0] cause = 4'h0;
  logic turning = 1'b0;
  logic alarm_n, red, green, drive, cw, pot;
  logic [3:0] code;
  stop_mode_t mode;
  logic [31:0] r;
  logic [3:0] codes [9] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'h7, 4'h8, 4'hA};
  int mismatches = 0;
  int total_checks = 0;
  int seed = 32'h7473e786;
  int n;

  // The clock runs free at 10 MHz.
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  motor_alarm_run_control #(.HOLD_CYC(HOLD), .PHASE_CYC(3), .GAP_CYC(8)) DUT (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .run_request_i(lvl[0]),
    .hold_release_input_i(lvl[1]), .direction_select_input_i(lvl[2]),
    .speed_source_select_i(lvl[3]), .alarm_clear_input_i(lvl[4]),
    .alarm_cause_i(cause), .motor_turning_i(turning), .alarm_inactive_output_o(alarm_n),
    .power_alarm_indicator_red_o(red), .power_alarm_indicator_green_o(green),
    .alarm_code_o(code), .drive_enable_o(drive), .direction_cw_o(cw),
    .use_internal_speed_pot_o(pot), .stop_mode_o(mode));

  ctrl_model #(.MIN_HOLD(2 * HOLD)) ctrl (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .want_i(want), .rude_i(rude), .lvl_o(lvl));

  function automatic logic is_fatal(input logic [3:0] c);
    return c == 4'h7 || c == 4'h8 || c == 4'hA;
  endfunction

  function automatic stop_mode_t exp_stop(input logic run, input logic hold);
    return !hold ? STOP_FAST : (!run ? STOP_DECEL : STOP_NONE);
  endfunction

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Inputs always move 10 ns after the rising edge, clear of the sampling instant.
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #10;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for the controller to show the levels, then for the filter to accept them.
  task automatic apply(input logic [4:0] w);
    int k;
    want = w;
    for (k = 0; k < 64 && lvl !== w; k++) begin
      tick(1);
    end
    if (lvl !== w) begin
      mismatches++;
      tally_and_finish();
    end
    tick(HOLD + 4);
  endtask

  // Syncs on a long dark gap, then counts flashes up to the next gap.
  task automatic count_blinks(output int cnt);
    int low;
    int k;
    low = 0;
    cnt = 0;
    for (k = 0; k < 400 && low < 6; k++) begin
      tick(1);
      low = red ? 0 : low + 1;
    end
    if (low < 6) begin
      mismatches++;
      tally_and_finish();
    end
    // The tail of the sync gap must not end the count before any flash is seen.
    low = 1;
    for (k = 0; k < 400 && (cnt == 0 || low < 6); k++) begin
      tick(1);
      if (red && low > 0) cnt++;
      low = red ? 0 : low + 1;
    end
    if (low < 6) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  initial begin
    tick(20);
    rst_n_i = 1'b1;
    tick(2);
    chk(alarm_n, 1'b1);
    chk(code, 4'h0);
    repeat (4) begin
      r = $random(seed);
      apply({1'b0, r[1:0], 2'b11});
      chk(drive, 1'b1);
      chk(cw, r[0]);
      chk(pot, r[1]);
    end
    turning = 1'b1;
    for (int i = 0; i < 3; i++) begin
      apply(5'h03);
      apply(5'(i));
      chk(drive, 1'b0);
      chk(mode, exp_stop(i[0], i[1]));
    end
    apply(5'h03);
    apply(5'h02);
    apply(5'h00);
    chk(mode, STOP_FAST);
    foreach (codes[j]) begin
      apply(5'h03);
      turning = 1'b1;
      cause = codes[j];
      tick(2);
      chk(drive, 1'b0);
      chk(alarm_n, 1'b0);
      chk(mode, STOP_COAST);
      cause = 4'h0;
      if (codes[j] == 4'hA) begin
        tick(40);
        chk(red, 1'b1);
      end else begin
        count_blinks(n);
        chk(n[3:0], codes[j]);
      end
      chk(code, codes[j]);
      chk(drive, 1'b0);
      rude = 1'b1;
      apply(5'h13);
      apply(5'h03);
      rude = 1'b0;
      chk(alarm_n, 1'b0);
      turning = 1'b0;
      apply(5'h10);
      chk(alarm_n, 1'b0);
      apply(5'h00);
      chk(alarm_n, !is_fatal(codes[j]));
      chk(green, !is_fatal(codes[j]));
      if (is_fatal(codes[j])) begin
        rst_n_i = 1'b0;
        tick(2);
        rst_n_i = 1'b1;
        tick(2);
        chk(alarm_n, 1'b1);
        chk(code, 4'h0);
      end
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
